/* File: include/csm_pkg.sv */
// Purpose: shared constants for the codec serial mode control block
// Assumes: one clock; the serial clock equals the block clock
// Notes:   field positions, register addresses, reset values, frame rates
package csm_pkg;
  // ****************************************************************
  // serial word layout
  // ****************************************************************
  localparam int WORD_W      = 16;     // bits in every serial frame
  localparam int CTL_FLAG    = 15;     // 1 = control word
  localparam int RW_BIT      = 14;     // 1 = read back, 0 = write
  localparam int DEV_HI      = 13;     // device address field top
  localparam int DEV_LO      = 11;     // device address field bottom
  localparam int REG_HI      = 10;     // register address field top
  localparam int REG_LO      = 8;      // register address field bottom
  localparam int DATA_HI     = 7;      // register data field top
  // ****************************************************************
  // register addresses inside a control word
  // ****************************************************************
  localparam logic [2:0] REG_FIRST   = 3'h0; // first_control_reg
  localparam logic [2:0] REG_CLKDIV  = 3'h1; // clock_divider_reg
  localparam logic [2:0] REG_POWER   = 3'h2; // power register
  localparam logic [2:0] REG_GAIN    = 3'h3; // gain_mute_control
  localparam logic [2:0] REG_ADVANCE = 3'h4; // output_advance_control
  // ****************************************************************
  // first_control_reg fields
  // ****************************************************************
  localparam int MODE_POS    = 0;      // operating_mode_bit
  localparam int MIXED_POS   = 1;      // mixed_bit
  localparam int ALB_POS     = 2;      // analog_loopback_bit
  localparam int DLB_POS     = 3;      // digital_loopback_bit
  localparam int DCNT_LO     = 4;      // device_count_field bottom
  localparam int DCNT_HI     = 6;      // device_count_field top
  localparam int SWRST_POS   = 7;      // software reset request
  // ****************************************************************
  // gain and advance fields
  // ****************************************************************
  localparam int MUTE_POS    = 7;      // output mute, 1 mutes
  localparam int MODRST_POS  = 3;      // modulator_reset_bit
  localparam int BYPASS_POS  = 5;      // interpolator_bypass_bit
  localparam logic [7:0] ADV_WMASK = 8'h3F; // bits 6 and 7 stay zero
  // ****************************************************************
  // reset values and frame rates
  // ****************************************************************
  localparam logic [7:0]  REG_RST   = 8'h00; // every register
  localparam logic [15:0] WORD_RST  = 16'h0000; // data words
  localparam int SLOW_DIV    = 2048;   // frame period after reset
  localparam int FAST_DIV    = 256;    // frame period after clock setup
  localparam int LOOP_DELAY  = 16;     // digital loop-back delay, cycles
endpackage

/* File: src/csm_buf2.sv */
// Purpose: two-entry valid/ready buffer on the transmit word path
// Assumes: single clock, asynchronous active-high reset
// Notes:   full and empty are exact; no word is dropped on a stall
`timescale 1ns/1ns
module csm_buf2 #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // filling side
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  // draining side
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  // ****************************************************************
  // storage
  // ****************************************************************
  logic [W-1:0] slot_ff [2];   // two words
  logic         rdPtr_ff;      // oldest slot
  logic         wrPtr_ff;      // next free slot
  logic [1:0]   count_ff;      // words held
  logic         doPush;        // accepted write
  logic         doPop;         // accepted read

  initial begin
    if (W < 1) $error("csm_buf2: width must be positive");
  end

  assign inReady  = (count_ff != 2'd2);
  assign outValid = (count_ff != 2'd0);
  assign outData  = slot_ff[rdPtr_ff];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  // write slot
  always_ff @(posedge clk) begin
    if (doPush) begin
      slot_ff[wrPtr_ff] <= inData;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdPtr_ff <= 1'b0;
      wrPtr_ff <= 1'b0;
      count_ff <= 2'd0;
    end else begin
      if (doPush) wrPtr_ff <= ~wrPtr_ff;
      if (doPop) rdPtr_ff <= ~rdPtr_ff;
      count_ff <= count_ff + {1'b0, doPush} - {1'b0, doPop};
    end
  end
endmodule // csm_buf2

/* File: src/csm_core.sv */
// Purpose: serial frame interpreter and operating-mode logic
// Assumes: serial bits move one per clk; frame syncs lead words by one cycle
// Notes:   words arriving while one is still pending are dropped
`timescale 1ns/1ns
module csm_core #(
  parameter int SLOW_DIV = csm_pkg::SLOW_DIV,
  parameter int FAST_DIV = csm_pkg::FAST_DIV
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // serial link
  input  wire logic        serialEnable,
  input  wire logic        serialIn,
  input  wire logic        inputFrameSync,
  output logic             serialOut,
  output logic             outputFrameSync,
  // converter side
  input  wire logic        adcValid,
  input  wire logic [15:0] adcSample,
  output logic [15:0]      dacData,
  output logic             dacLoad,
  // register contents
  output logic [2:0]       inputGainSel,
  output logic [2:0]       outputGainSel,
  output logic             modulatorReset,
  output logic             outputMute,
  output logic [4:0]       converterAdvance,
  output logic             interpolatorBypass,
  output logic [7:0]       powerControl,
  output logic [7:0]       clockDividerReg,
  // mode status
  output logic             dataMode,
  output logic             mixedMode,
  output logic             analogLoopback,
  output logic             digitalLoopback
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam int DIV_W = $clog2(SLOW_DIV);
  localparam int WW    = csm_pkg::WORD_W;

  initial begin
    if (FAST_DIV < 2 * WW + 2 || SLOW_DIV < FAST_DIV)
      $error("csm_core: frame periods too short for 16-bit frames");
  end

  logic [7:0]       firstReg_ff;     // first_control_reg
  logic [7:0]       clkReg_ff;       // clock_divider_reg
  logic [7:0]       powerReg_ff;     // power register
  logic [7:0]       gainReg_ff;      // gain_mute_control
  logic [7:0]       advReg_ff;       // output_advance_control
  logic             fastRate_ff;     // clock register has been written
  logic [DIV_W-1:0] frameCnt_ff;     // frame period counter
  logic             frameEvt;        // output sample event
  logic             rxBusy_ff;       // receiving a word
  logic [3:0]       rxBit_ff;        // received bit count
  logic [WW-1:0]    rxShift_ff;      // receive shifter
  logic             rxDone;          // last bit arrives now
  logic [WW-1:0]    rxWordIn;        // completed word
  logic [WW-1:0]    pendWord_ff;     // word waiting for interpretation
  logic             pend_ff;         // pending word held
  logic [2:0]       slotCnt_ff;      // data frame position in cascade
  logic [2:0]       devCount;        // device_count_field
  logic             isCtl;           // pending word is control
  logic             ctlMine;         // control word for this device
  logic             needTx;          // word must be sent out
  logic [WW-1:0]    txWordReq;       // word to send
  logic             doWork;          // interpret pending word now
  logic             isSample;        // pending word is a sample
  logic             bufValid;        // buffer holds a word
  logic [WW-1:0]    bufData;         // oldest buffered word
  logic             bufReady;        // buffer has room
  logic             txTake;          // transmitter takes a word
  logic             txBusy_ff;       // sending a word
  logic [3:0]       txBit_ff;        // sent bit count
  logic [WW-1:0]    txShift_ff;      // transmit shifter
  logic [WW-1:0]    loopData_ff;     // digital loop-back data delay
  logic [WW-1:0]    loopSync_ff;     // digital loop-back sync delay
  logic [7:0]       selReg;          // register picked for read back
  logic [WW-1:0]    adcOut;          // sample as sent to the host

  assign dataMode        = firstReg_ff[csm_pkg::MODE_POS];
  assign mixedMode       = firstReg_ff[csm_pkg::MIXED_POS] & dataMode;
  assign analogLoopback  = firstReg_ff[csm_pkg::ALB_POS];
  assign digitalLoopback = firstReg_ff[csm_pkg::DLB_POS];
  assign devCount        = firstReg_ff[csm_pkg::DCNT_HI:csm_pkg::DCNT_LO];

  // register fields to the converter side
  assign inputGainSel       = gainReg_ff[2:0];
  assign modulatorReset     = gainReg_ff[csm_pkg::MODRST_POS];
  assign outputGainSel      = gainReg_ff[6:4];
  assign outputMute         = gainReg_ff[csm_pkg::MUTE_POS];
  assign converterAdvance   = advReg_ff[4:0];
  assign interpolatorBypass = advReg_ff[csm_pkg::BYPASS_POS];
  assign powerControl       = powerReg_ff;
  assign clockDividerReg    = clkReg_ff;

  // ****************************************************************
  // frame timing
  // ****************************************************************

  // output sample events, slow until the clock register is set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frameCnt_ff <= '0;
    end else if (!serialEnable) begin
      frameCnt_ff <= '0;
    end else if (frameEvt) begin
      frameCnt_ff <= '0;
    end else begin
      frameCnt_ff <= frameCnt_ff + 1'b1;
    end
  end

  assign frameEvt = serialEnable &&
    (fastRate_ff ? (frameCnt_ff == DIV_W'(FAST_DIV - 1))
                 : (frameCnt_ff == DIV_W'(SLOW_DIV - 1)));

  // ****************************************************************
  // receiver
  // ****************************************************************

  // shift in 16 bits after each input frame sync
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxBusy_ff  <= 1'b0;
      rxBit_ff   <= 4'd0;
      rxShift_ff <= csm_pkg::WORD_RST;
    end else begin
      if (inputFrameSync && (!rxBusy_ff || rxDone)) begin
        rxBusy_ff <= 1'b1;                 // continuous frames allowed
        rxBit_ff  <= 4'd0;
      end else if (rxDone) begin
        rxBusy_ff <= 1'b0;
      end else if (rxBusy_ff) begin
        rxBit_ff <= rxBit_ff + 4'd1;
      end
      if (rxBusy_ff) begin
        rxShift_ff <= {rxShift_ff[WW-2:0], serialIn};
      end
    end
  end

  assign rxDone   = rxBusy_ff && (rxBit_ff == 4'd15);
  assign rxWordIn = {rxShift_ff[WW-2:0], serialIn};

  // ****************************************************************
  // interpretation
  // ****************************************************************
  assign isCtl   = pendWord_ff[csm_pkg::CTL_FLAG]
                   && (!dataMode || mixedMode);
  assign ctlMine = isCtl &&
    (pendWord_ff[csm_pkg::DEV_HI:csm_pkg::DEV_LO] == 3'd0);

  // read back picks the addressed register
  always_comb begin
    unique case (pendWord_ff[csm_pkg::REG_HI:csm_pkg::REG_LO])
      csm_pkg::REG_FIRST:   selReg = firstReg_ff;
      csm_pkg::REG_CLKDIV:  selReg = clkReg_ff;
      csm_pkg::REG_POWER:   selReg = powerReg_ff;
      csm_pkg::REG_GAIN:    selReg = gainReg_ff;
      csm_pkg::REG_ADVANCE: selReg = advReg_ff;
      default:              selReg = csm_pkg::REG_RST;
    endcase
  end

  // forwarded or read-back words go out through the buffer
  always_comb begin
    needTx    = 1'b0;
    txWordReq = pendWord_ff;
    if (isCtl && !ctlMine) begin
      needTx    = 1'b1;
      txWordReq[csm_pkg::DEV_HI:csm_pkg::DEV_LO] =
        pendWord_ff[csm_pkg::DEV_HI:csm_pkg::DEV_LO] - 3'd1;
    end else if (ctlMine && pendWord_ff[csm_pkg::RW_BIT]) begin
      needTx    = 1'b1;
      txWordReq = {pendWord_ff[WW-1:8], selReg};
    end
  end

  assign doWork   = pend_ff && (!needTx || bufReady);
  assign isSample = dataMode && !isCtl && !analogLoopback;

  // hold one received word until it can be interpreted
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_ff     <= 1'b0;
      pendWord_ff <= csm_pkg::WORD_RST;
    end else if (rxDone && !digitalLoopback && (!pend_ff || doWork)) begin
      pend_ff     <= 1'b1;
      pendWord_ff <= rxWordIn;
    end else if (doWork) begin
      pend_ff     <= 1'b0;
    end
  end

  // position of each data frame within the cascade
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slotCnt_ff <= 3'd0;
    end else if (!dataMode) begin
      slotCnt_ff <= 3'd0;
    end else if (doWork && isSample) begin
      slotCnt_ff <= (slotCnt_ff == devCount) ? 3'd0
                                             : slotCnt_ff + 3'd1;
    end
  end

  // converter register loads
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dacData <= csm_pkg::WORD_RST;
      dacLoad <= 1'b0;
    end else begin
      dacLoad <= 1'b0;
      if (analogLoopback && adcValid) begin
        dacData <= adcSample;
        dacLoad <= 1'b1;
      end else if (doWork && isSample && slotCnt_ff == devCount) begin
        dacData <= mixedMode ? {pendWord_ff[WW-2:0], 1'b0}
                             : pendWord_ff;
        dacLoad <= 1'b1;
      end
    end
  end

  // control register writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      firstReg_ff <= csm_pkg::REG_RST;
      clkReg_ff   <= csm_pkg::REG_RST;
      powerReg_ff <= csm_pkg::REG_RST;
      gainReg_ff  <= csm_pkg::REG_RST;
      advReg_ff   <= csm_pkg::REG_RST;
      fastRate_ff <= 1'b0;
    end else if (doWork && ctlMine && !pendWord_ff[csm_pkg::RW_BIT]) begin
      unique case (pendWord_ff[csm_pkg::REG_HI:csm_pkg::REG_LO])
        csm_pkg::REG_FIRST: begin
          if (pendWord_ff[csm_pkg::SWRST_POS]) begin
            firstReg_ff <= csm_pkg::REG_RST;   // software reset request
          end else begin
            firstReg_ff <= pendWord_ff[7:0];
            if (!mixedMode) begin
              firstReg_ff[csm_pkg::ALB_POS] <= analogLoopback
                | pendWord_ff[csm_pkg::ALB_POS];
              firstReg_ff[csm_pkg::DLB_POS] <= digitalLoopback
                | pendWord_ff[csm_pkg::DLB_POS];
            end
          end
        end
        csm_pkg::REG_CLKDIV: begin
          clkReg_ff   <= pendWord_ff[7:0];
          fastRate_ff <= 1'b1;
        end
        csm_pkg::REG_POWER:   powerReg_ff <= pendWord_ff[7:0];
        csm_pkg::REG_GAIN:    gainReg_ff  <= pendWord_ff[7:0];
        csm_pkg::REG_ADVANCE: advReg_ff   <= pendWord_ff[7:0]
                                             & csm_pkg::ADV_WMASK;
        default: ;                             // unused register address
      endcase
    end
  end

  // ****************************************************************
  // transmit buffer
  // ****************************************************************
  csm_buf2 #(
    .W (WW)
  ) u_txBuf (
    .clk      (clk),
    .reset    (reset),
    .inValid  (pend_ff && needTx),
    .inData   (txWordReq),
    .inReady  (bufReady),
    .outValid (bufValid),
    .outData  (bufData),
    .outReady (txTake)
  );

  // ****************************************************************
  // transmitter
  // ****************************************************************
  assign txTake = frameEvt && bufValid && !digitalLoopback;
  assign adcOut = mixedMode ? {1'b0, adcSample[WW-2:0]}
                            : adcSample;

  // one word per sample event, queued words before samples
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txBusy_ff  <= 1'b0;
      txBit_ff   <= 4'd0;
      txShift_ff <= csm_pkg::WORD_RST;
    end else if (frameEvt) begin
      txBusy_ff  <= 1'b1;
      txBit_ff   <= 4'd0;
      txShift_ff <= bufValid ? bufData : adcOut;
    end else if (txBusy_ff) begin
      txShift_ff <= {txShift_ff[WW-2:0], 1'b0};
      txBit_ff   <= txBit_ff + 4'd1;
      if (txBit_ff == 4'd15) txBusy_ff <= 1'b0;
    end
  end

  // digital loop-back delay lines
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loopData_ff <= csm_pkg::WORD_RST;
      loopSync_ff <= csm_pkg::WORD_RST;
    end else begin
      loopData_ff <= {loopData_ff[WW-2:0], serialIn};
      loopSync_ff <= {loopSync_ff[WW-2:0], inputFrameSync};
    end
  end

  // serial output pins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serialOut       <= 1'b0;
      outputFrameSync <= 1'b0;
    end else if (digitalLoopback) begin
      serialOut       <= loopData_ff[csm_pkg::LOOP_DELAY-2];
      outputFrameSync <= loopSync_ff[csm_pkg::LOOP_DELAY-2];
    end else begin
      serialOut       <= frameEvt ? 1'b0 : (txBusy_ff & txShift_ff[WW-1]);
      outputFrameSync <= frameEvt;
    end
  end
endmodule // csm_core

/* File: verification/csm_core_props.sv */
// Purpose: concurrent checks on the core's ports
// Assumes: one clock domain, async active-high reset
// Notes:   bound to csm_core from the bench top file
`timescale 1ns/1ns
module csm_core_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // serial link
  input wire logic        serialEnable,
  input wire logic        serialIn,
  input wire logic        inputFrameSync,
  input wire logic        serialOut,
  input wire logic        outputFrameSync,
  // converter side
  input wire logic        adcValid,
  input wire logic [15:0] dacData,
  input wire logic        dacLoad,
  // registers and modes
  input wire logic [2:0]  inputGainSel,
  input wire logic [2:0]  outputGainSel,
  input wire logic        outputMute,
  input wire logic        dataMode,
  input wire logic        mixedMode,
  input wire logic        analogLoopback,
  input wire logic        digitalLoopback
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ****
  // port checks
  // ****
  sync_idle_a: assert property (!serialEnable && !$past(serialEnable) |-> !outputFrameSync)
    else $error("frame sync while serial disabled");
  sync_gap_a: assert property (outputFrameSync |=> !outputFrameSync [*8])
    else $error("frame syncs too close");
  load_gap_a: assert property (dacLoad |=> !dacLoad [*8])
    else $error("converter loads too close");
  mixed_lsb_a: assert property (dacLoad && mixedMode && !analogLoopback |-> !dacData[0])
    else $error("mixed sample lsb not zero");
  alb_copy_a: assert property (analogLoopback && adcValid |-> ##[1:3] dacLoad)
    else $error("loop-back sample not loaded");
  alb_hold_a: assert property (analogLoopback && !mixedMode |=> analogLoopback)
    else $error("analog loop-back left without mixed");
  dlb_hold_a: assert property (digitalLoopback && !mixedMode |=> digitalLoopback)
    else $error("digital loop-back left without mixed");
  dlb_echo_a: assert property (digitalLoopback && $past(digitalLoopback, 17)
    |-> serialOut == $past(serialIn, 16) && outputFrameSync == $past(inputFrameSync, 16))
    else $error("loop-back echo wrong");
  data_lock_a: assert property (dataMode && !mixedMode
    |=> $stable({inputGainSel, outputGainSel, outputMute}))
    else $error("register changed in data mode");
endmodule // csm_core_props

/* File: verification/csm_host.sv */
// Purpose: host serial port model facing the core
// Assumes: bits change at the falling edge, one per clk
// Notes:   idle data line toggles so stale bits never look valid
`timescale 1ns/1ns
module csm_host (
  // from core
  input  wire logic clk,
  input  wire logic serialOut,
  input  wire logic outputFrameSync,
  // to core
  output logic      serialIn,
  output logic      inputFrameSync
);
  logic busy = 1'b0; // word in flight
  logic bitQ = 1'b0; // current bit
  logic tog  = 1'b0; // idle pattern
  // idle data toggles every cycle
  always @(negedge clk) tog <= ~tog;
  assign serialIn = busy ? bitQ : tog;
  initial inputFrameSync = 1'b0;
  // sync one cycle ahead, then msb first
  task automatic send(input logic [15:0] w);
    @(negedge clk);
    busy = 1'b1;
    inputFrameSync = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk);
      inputFrameSync = 1'b0;
      bitQ = w[i];
    end
    @(negedge clk);
    busy = 1'b0;
  endtask
  // take one output word after its frame sync
  task automatic grab(output logic [15:0] w, output logic ok);
    ok = 1'b0;
    w = 16'h0000;
    for (int n = 0; n < 300 && !ok; n++) begin
      @(negedge clk);
      ok = (outputFrameSync === 1'b1);
    end
    for (int i = 0; i < 16 && ok; i++) begin
      @(negedge clk);
      w = {w[14:0], serialOut};
    end
  endtask
endmodule // csm_host

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for the serial mode control core
// Assumes: frame periods shortened through core parameters
// Notes:   host model drives the serial link
`timescale 1ns/1ns
module tb_top;
  localparam int SLOW = 64; // short slow frame period
  localparam int FAST = 34; // short fast frame period
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        serialEnable = 1'b0;
  logic        adcValid;   // converter sample strobe, set by adc()
  logic [15:0] adcSample;  // converter sample value, set by adc()
  logic        serialIn, inputFrameSync, serialOut, outputFrameSync, dacLoad;
  logic        modulatorReset, outputMute, interpolatorBypass;
  logic        dataMode, mixedMode, analogLoopback, digitalLoopback;
  logic [15:0] dacData, w;
  logic [2:0]  inputGainSel, outputGainSel;
  logic [4:0]  converterAdvance;
  logic [7:0]  powerControl, clockDividerReg;
  logic        ok;
  int          nFail = 0;
  int          totalChecks = 0;
  csm_core #(.SLOW_DIV(SLOW), .FAST_DIV(FAST)) dut (.clk, .reset, .serialEnable, .serialIn,
    .inputFrameSync, .serialOut, .outputFrameSync, .adcValid, .adcSample, .dacData, .dacLoad,
    .inputGainSel, .outputGainSel, .modulatorReset, .outputMute, .converterAdvance,
    .interpolatorBypass, .powerControl, .clockDividerReg, .dataMode, .mixedMode,
    .analogLoopback, .digitalLoopback);
  csm_host host (.clk, .serialOut, .outputFrameSync, .serialIn, .inputFrameSync);
  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rst();
    reset = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
  endtask
  // converter side stimulus, changed only at the falling edge
  task automatic adc(input logic [15:0] s, input logic v);
    adcSample = s;
    adcValid  = v;
  endtask
  // control write to device zero
  task automatic wr(input logic [2:0] ra, input logic [7:0] d);
    host.send({2'b10, 3'h0, ra, d});
    repeat (3) @(negedge clk);
  endtask
  task automatic waitLoad();
    int n;
    n = 0;
    while (dacLoad !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    if (n == 12) begin
      nFail++;
      end_sim();
    end
  endtask
  // frame period after the next sync
  task automatic gap(input int exp);
    int n;
    n = 0;
    host.grab(w, ok);
    while (outputFrameSync !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n + 16), 16'(exp));
  endtask
  // ****
  // scenarios
  // ****
  task automatic sc_regs();
    chk({dataMode, mixedMode, analogLoopback, digitalLoopback}, 16'h0000);
    wr(csm_pkg::REG_GAIN, 8'hA5);
    chk({outputMute, outputGainSel, modulatorReset, inputGainSel}, 16'h00A5);
    wr(csm_pkg::REG_ADVANCE, 8'h2A);
    chk({interpolatorBypass, converterAdvance}, 16'h002A);
    wr(csm_pkg::REG_POWER, 8'h39);
    chk(powerControl, 16'h0039);
    host.send(16'h0312);
    repeat (3) @(negedge clk);
    chk({outputMute, outputGainSel, modulatorReset, inputGainSel}, 16'h00A5);
  endtask
  task automatic sc_fwd();
    host.send(16'h9311);
    repeat (3) @(negedge clk);
    chk({outputMute, outputGainSel, modulatorReset, inputGainSel}, 16'h00A5);
    for (int i = 0; i < 3 && w !== 16'h8B11; i++) host.grab(w, ok);
    chk(w, 16'h8B11);
    host.send(16'hC300);
    for (int i = 0; i < 3 && w !== 16'hC3A5; i++) host.grab(w, ok);
    chk(w, 16'hC3A5);
  endtask
  task automatic sc_rate();
    serialEnable = 1'b0;
    repeat (100) @(negedge clk);
    serialEnable = 1'b1;
    gap(SLOW);
    wr(csm_pkg::REG_CLKDIV, 8'h03);
    chk(clockDividerReg, 16'h0003);
    gap(FAST);
  endtask
  task automatic sc_mixed();
    rst();
    wr(csm_pkg::REG_FIRST, 8'h03);
    chk(mixedMode, 16'h0001);
    host.send(16'h1235);
    waitLoad();
    chk(dacData, 16'h246A);
    wr(csm_pkg::REG_GAIN, 8'h12);
    chk({outputMute, outputGainSel, modulatorReset, inputGainSel}, 16'h0012);
    adc(16'hFFFF, 1'b0);
    host.grab(w, ok);
    host.grab(w, ok);
    chk(w, 16'h7FFF);
    wr(csm_pkg::REG_FIRST, 8'h07);
    chk(analogLoopback, 16'h0001);
    wr(csm_pkg::REG_FIRST, 8'h03);
    chk(analogLoopback, 16'h0000);
  endtask
  task automatic sc_data();
    for (int c = 1; c >= 0; c--) begin
      rst();
      wr(csm_pkg::REG_FIRST, {1'b0, 3'(c), 4'h1});
      host.send(16'hC3A0);
      if (c == 1) begin
        repeat (3) @(negedge clk);
        chk(dacData, 16'h0000);
        host.send(16'hC3A1);
      end
      waitLoad();
      chk(dacData, 16'(16'hC3A0 + c));
    end
    host.send(16'h8377);
    waitLoad();
    chk(dacData, 16'h8377);
    chk({outputMute, outputGainSel, modulatorReset, inputGainSel}, 16'h0000);
  endtask
  task automatic sc_loop();
    rst();
    wr(csm_pkg::REG_FIRST, 8'h04);
    adc(16'h4321, 1'b1);
    @(negedge clk);
    adc(16'h4321, 1'b0);
    waitLoad();
    chk(dacData, 16'h4321);
    wr(csm_pkg::REG_FIRST, 8'h00);
    chk(analogLoopback, 16'h0001);
    rst();
    wr(csm_pkg::REG_FIRST, 8'h08);
    fork
      host.send(16'hA55A);
      host.grab(w, ok);
    join
    chk(w, 16'hA55A);
  endtask
  initial forever #20 clk = ~clk;
  initial begin
    adc(16'h0000, 1'b0);
    rst();
    serialEnable = 1'b1;
    sc_regs();
    sc_fwd();
    sc_rate();
    sc_mixed();
    sc_data();
    sc_loop();
    end_sim();
  end
endmodule // tb_top
bind csm_core csm_core_props u_props (.clk, .reset, .serialEnable, .serialIn, .inputFrameSync,
  .serialOut, .outputFrameSync, .adcValid, .dacData, .dacLoad, .inputGainSel, .outputGainSel,
  .outputMute, .dataMode, .mixedMode, .analogLoopback, .digitalLoopback);
